// [verilog/invalidation_descriptor_executor.sv]
`include "inv_exec_map.svh"
`default_nettype none
module invalidation_descriptor_executor
  import inv_exec_pkg::*;
#(
  parameter bit WRITE_BUFFER_FLUSH_REQUIRED = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // descriptor stream from the queue fetcher
  input wire logic dsc_valid,
  input wire logic [127:0] dsc_data,
  output logic dsc_ready,
  // write buffer flush
  output logic wbf_req,
  input wire logic wbf_ack,
  // translation cache invalidation
  output logic tc_inv_req,
  output tc_req_t tc_inv,
  input wire logic tc_inv_ack,
  // dma draining
  output logic drain_rd_req,
  output logic drain_wr_req,
  input wire logic drain_ack,
  // endpoint translation cache invalidation
  output logic ep_inv_req,
  output ep_req_t ep_inv,
  input wire logic ep_inv_ack,
  input wire logic ep_inv_cpl,
  // interrupt entry cache invalidation and interrupt draining
  output logic iec_inv_req,
  output iec_req_t iec_inv,
  input wire logic iec_inv_ack,
  output logic int_drain_req,
  input wire logic int_drain_ack,
  // wait completion status write and event
  output logic status_wr_req,
  output status_wr_t status_wr,
  input wire logic status_wr_ack,
  output logic cpl_event
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  exec_state_t state_ff, nxt_state;
  logic [127:0] dsc_ff;
  logic [5:0] ep_pend_ff, nxt_ep_pend;
  logic drain_rd_pend_ff, drain_wr_pend_ff;
  logic wait_complete_flag_ff, nxt_wait_complete_flag;
  logic interrupt_pending_bit_ff, nxt_interrupt_pending_bit;
  logic completion_interrupt_mask_ff, nxt_completion_interrupt_mask;
  logic bad_type_ff, nxt_bad_type;
  logic cpl_event_ff, nxt_cpl_event;

  // ---------------------------------------------------------------
  // descriptor decode
  // ---------------------------------------------------------------
  wire logic [3:0] in_type = dsc_data[`D_TYPE_HI:`D_TYPE_LO];
  wire logic [3:0] cur_type = dsc_ff[`D_TYPE_HI:`D_TYPE_LO];
  wire logic take = dsc_valid && dsc_ready;
  wire logic in_tc = (in_type == `DT_TC);
  wire logic in_ep = (in_type == `DT_EP);
  wire logic in_iec = (in_type == `DT_IEC);
  wire logic in_wait = (in_type == `DT_WAIT);
  wire logic in_bad = !(in_tc || in_ep || in_iec || in_wait);
  wire logic cur_is_tc = (cur_type == `DT_TC);

  // translation cache request: unused fields forced to zero per granularity
  wire logic [1:0] tc_gran_raw = dsc_ff[`TC_GRAN_HI:`TC_GRAN_LO];
  // an unknown code falls back to global, which is always coarse enough
  wire logic [1:0] tc_gran = (tc_gran_raw == `GRAN_DOMAIN || tc_gran_raw == `GRAN_PAGE) ?
                              tc_gran_raw : `GRAN_GLOBAL;
  wire logic tc_is_page = (tc_gran == `GRAN_PAGE);
  wire logic tc_is_global = (tc_gran == `GRAN_GLOBAL);

  assign tc_inv.gran = tc_gran;
  assign tc_inv.domain = tc_is_global ? 16'h0000 : dsc_ff[`TC_DID_HI:`TC_DID_LO];
  assign tc_inv.page = tc_is_page ? dsc_ff[`D_PAGE_HI:`D_PAGE_LO] : 52'h0;
  assign tc_inv.page_count_mask = tc_is_page ? dsc_ff[`TC_AM_HI:`TC_AM_LO] : 6'h00;
  assign tc_inv.directory_keep_hint = tc_is_page && dsc_ff[`TC_IH];

  // endpoint request: the endpoint decodes the range from the lowest zero bit
  assign ep_inv.requester_identifier = dsc_ff[`EP_RID_HI:`EP_RID_LO];
  assign ep_inv.page = dsc_ff[`D_PAGE_HI:`D_PAGE_LO];
  assign ep_inv.size = dsc_ff[`EP_SIZE];

  wire logic [4:0] pending_limit_hint = dsc_ff[`EP_HINT_HI:`EP_HINT_LO];
  wire logic [5:0] ep_limit = (pending_limit_hint == 5'h00) ? `EP_MAX_PEND :
                              {1'b0, pending_limit_hint};
  wire logic ep_room = (ep_pend_ff < ep_limit);

  // interrupt entry cache request
  assign iec_inv.global_inv = !dsc_ff[`IEC_GRAN];
  assign iec_inv.interrupt_entry_index = dsc_ff[`IEC_IDX_HI:`IEC_IDX_LO];
  // the cache ignores the low index_mask bits of the index
  assign iec_inv.index_mask = dsc_ff[`IEC_GRAN] ? dsc_ff[`IEC_IM_HI:`IEC_IM_LO] : 5'h00;

  // wait descriptor
  wire logic wt_if = dsc_ff[`WT_IF];
  wire logic status_write_enable = dsc_ff[`WT_SW];
  wire logic fence_flag = dsc_ff[`WT_FN];
  assign status_wr.addr = status_write_enable ? dsc_ff[`WT_ADDR_HI:`WT_ADDR_LO] : 62'h0;
  assign status_wr.data = status_write_enable ? dsc_ff[`WT_DATA_HI:`WT_DATA_LO] : 32'h0;

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  // one descriptor at a time: the fence is always honoured, and a wait with
  // the fence clear is simply not overlapped, trading speed for simplicity
  assign dsc_ready = (state_ff == ST_IDLE);
  assign wbf_req = (state_ff == ST_WBF);
  assign tc_inv_req = (state_ff == ST_TC);
  assign ep_inv_req = (state_ff == ST_EP) && ep_room;
  assign iec_inv_req = (state_ff == ST_IEC);
  assign int_drain_req = (state_ff == ST_IDRAIN);
  assign status_wr_req = (state_ff == ST_SWRITE);

  // a wait finishes only once every endpoint request has returned
  wire logic ep_idle = (ep_pend_ff == 6'h00);
  wire logic in_wait_st = (state_ff == ST_WAIT);
  assign drain_rd_req = in_wait_st && ep_idle && drain_rd_pend_ff;
  assign drain_wr_req = in_wait_st && ep_idle && drain_wr_pend_ff;
  wire logic drains_busy = drain_rd_pend_ff || drain_wr_pend_ff;
  wire logic wait_ready = in_wait_st && ep_idle && !drains_busy;

  wire logic ep_issue = ep_inv_req && ep_inv_ack;
  wire logic wait_done = (wait_ready && !status_write_enable) ||
                         ((state_ff == ST_SWRITE) && status_wr_ack);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take && (in_tc || in_iec)) begin
          nxt_state = WRITE_BUFFER_FLUSH_REQUIRED ? ST_WBF : (in_tc ? ST_TC : ST_IEC);
        end else if (take && in_ep) begin
          nxt_state = ST_EP;
        end else if (take && in_wait) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WBF: begin
        if (wbf_ack) begin
          nxt_state = cur_is_tc ? ST_TC : ST_IEC;
        end
      end
      ST_TC: begin
        if (tc_inv_ack) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_EP: begin
        if (ep_issue) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IEC: begin
        if (iec_inv_ack) begin
          nxt_state = ST_IDRAIN;
        end
      end
      ST_IDRAIN: begin
        if (int_drain_ack) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (wait_ready) begin
          nxt_state = status_write_enable ? ST_SWRITE : ST_IDLE;
        end
      end
      ST_SWRITE: begin
        if (status_wr_ack) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // endpoint requests in flight
  always_comb begin
    nxt_ep_pend = ep_pend_ff;
    if (ep_issue && !ep_inv_cpl) begin
      nxt_ep_pend = ep_pend_ff + 6'h01;
    end else if (!ep_issue && ep_inv_cpl && !ep_idle) begin
      nxt_ep_pend = ep_pend_ff - 6'h01;
    end
  end

  // drain requests collected since the previous wait
  wire logic tc_done = tc_inv_req && tc_inv_ack;
  wire logic drain_fin = (drain_rd_req || drain_wr_req) && drain_ack;
  wire logic nxt_drain_rd = (drain_rd_pend_ff && !drain_fin) || (tc_done && dsc_ff[`TC_DR]);
  wire logic nxt_drain_wr = (drain_wr_pend_ff && !drain_fin) || (tc_done && dsc_ff[`TC_DW]);

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  wire logic sel_cpl = (paddr == `REG_CPL_STATUS);
  wire logic sel_ctrl = (paddr == `REG_EVT_CTRL);
  wire logic sel_cap = (paddr == `REG_CAPABILITY);
  wire logic sel_exec = (paddr == `REG_EXEC_STATUS);
  wire logic mapped = sel_cpl || sel_ctrl || sel_cap || sel_exec;
  // reads wait behind an open status write so they push it out first
  assign pready = (state_ff != ST_SWRITE);
  assign pslverr = psel && penable && !mapped;
  wire logic acc = psel && penable && pready && mapped;
  wire logic wr_cpl = acc && pwrite && sel_cpl;
  wire logic wr_ctrl = acc && pwrite && sel_ctrl;
  wire logic wr_exec = acc && pwrite && sel_exec;

  always_comb begin
    prdata = 32'h0;
    if (sel_cpl) begin
      prdata[`WC_BIT] = wait_complete_flag_ff;
    end else if (sel_ctrl) begin
      prdata[`MASK_BIT] = completion_interrupt_mask_ff;
      prdata[`PEND_BIT] = interrupt_pending_bit_ff;
    end else if (sel_cap) begin
      prdata[0] = WRITE_BUFFER_FLUSH_REQUIRED;
    end else if (sel_exec) begin
      prdata[5:0] = ep_pend_ff;
      prdata[7] = (state_ff != ST_IDLE);
      prdata[`BADTYPE_BIT] = bad_type_ff;
      prdata[9] = drain_rd_pend_ff;
      prdata[10] = drain_wr_pend_ff;
    end
  end

  // ---------------------------------------------------------------
  // completion event logic
  // ---------------------------------------------------------------
  wire logic set_wc = wait_done && wt_if;
  wire logic clr_wc = wr_cpl && pwdata[`WC_BIT];
  wire logic fresh_wc = set_wc && !wait_complete_flag_ff;
  wire logic unmask = wr_ctrl && !pwdata[`MASK_BIT] && completion_interrupt_mask_ff;

  always_comb begin
    nxt_wait_complete_flag = set_wc || (wait_complete_flag_ff && !clr_wc);
    nxt_completion_interrupt_mask = wr_ctrl ? pwdata[`MASK_BIT] : completion_interrupt_mask_ff;
    nxt_interrupt_pending_bit = interrupt_pending_bit_ff;
    nxt_cpl_event = 1'b0;
    if (fresh_wc) begin
      if (nxt_completion_interrupt_mask) begin
        nxt_interrupt_pending_bit = 1'b1;
      end else begin
        nxt_cpl_event = 1'b1;
        nxt_interrupt_pending_bit = 1'b0;
      end
    end else if (interrupt_pending_bit_ff && unmask) begin
      nxt_cpl_event = 1'b1;
      nxt_interrupt_pending_bit = 1'b0;
    end else if (interrupt_pending_bit_ff && clr_wc) begin
      nxt_interrupt_pending_bit = 1'b0;
    end
  end

  assign nxt_bad_type = (take && in_bad) || (bad_type_ff && !(wr_exec && pwdata[`BADTYPE_BIT]));
  // events go out on the wire directly, never through the remapping tables
  assign cpl_event = cpl_event_ff;

  // ---------------------------------------------------------------
  // flops
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      ep_pend_ff <= 6'h00;
      drain_rd_pend_ff <= 1'b0;
      drain_wr_pend_ff <= 1'b0;
      bad_type_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ep_pend_ff <= nxt_ep_pend;
      drain_rd_pend_ff <= nxt_drain_rd;
      drain_wr_pend_ff <= nxt_drain_wr;
      bad_type_ff <= nxt_bad_type;
    end
  end

  // the full 128-bit descriptor is held while its handler runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsc_ff <= 128'h0;
    end else if (take) begin
      dsc_ff <= dsc_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_complete_flag_ff <= 1'b0;
      interrupt_pending_bit_ff <= 1'b0;
      completion_interrupt_mask_ff <= `MASK_RESET;
      cpl_event_ff <= 1'b0;
    end else begin
      wait_complete_flag_ff <= nxt_wait_complete_flag;
      interrupt_pending_bit_ff <= nxt_interrupt_pending_bit;
      completion_interrupt_mask_ff <= nxt_completion_interrupt_mask;
      cpl_event_ff <= nxt_cpl_event;
    end
  end

endmodule
`default_nettype wire

// [verilog/inv_exec_map.svh]
`ifndef INV_EXEC_MAP_SVH
`define INV_EXEC_MAP_SVH

// register byte offsets
`define REG_CPL_STATUS 12'h000
`define REG_EVT_CTRL 12'h004
`define REG_CAPABILITY 12'h008
`define REG_EXEC_STATUS 12'h00c

// register fields and reset values
`define WC_BIT 0
`define MASK_BIT 31
`define PEND_BIT 30
`define BADTYPE_BIT 8
`define MASK_RESET 1'b1

// descriptor type codes
`define DT_TC 4'h2
`define DT_EP 4'h3
`define DT_IEC 4'h4
`define DT_WAIT 4'h5

// descriptor fields
`define D_TYPE_HI 3
`define D_TYPE_LO 0
`define TC_GRAN_HI 5
`define TC_GRAN_LO 4
`define TC_DW 6
`define TC_DR 7
`define TC_DID_HI 31
`define TC_DID_LO 16
`define TC_AM_HI 69
`define TC_AM_LO 64
`define TC_IH 70
`define D_PAGE_HI 127
`define D_PAGE_LO 76
`define EP_HINT_HI 20
`define EP_HINT_LO 16
`define EP_RID_HI 47
`define EP_RID_LO 32
`define EP_SIZE 64
`define IEC_GRAN 4
`define IEC_IM_HI 31
`define IEC_IM_LO 27
`define IEC_IDX_HI 47
`define IEC_IDX_LO 32
`define WT_IF 4
`define WT_SW 5
`define WT_FN 6
`define WT_DATA_HI 63
`define WT_DATA_LO 32
`define WT_ADDR_HI 127
`define WT_ADDR_LO 66

// translation-cache granularity codes
`define GRAN_GLOBAL 2'h1
`define GRAN_DOMAIN 2'h2
`define GRAN_PAGE 2'h3

// endpoint limit when the hint is zero
`define EP_MAX_PEND 6'h20

`endif

// [verilog/inv_exec_pkg.sv]
`default_nettype none
package inv_exec_pkg;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_WBF    = 8'h02,
    ST_TC     = 8'h04,
    ST_EP     = 8'h08,
    ST_IEC    = 8'h10,
    ST_IDRAIN = 8'h20,
    ST_WAIT   = 8'h40,
    ST_SWRITE = 8'h80
  } exec_state_t;

  typedef struct packed {
    logic [1:0]  gran;
    logic [15:0] domain;
    logic [51:0] page;
    logic [5:0]  page_count_mask;
    logic        directory_keep_hint;
  } tc_req_t;

  typedef struct packed {
    logic [15:0] requester_identifier;
    logic [51:0] page;
    logic        size;
  } ep_req_t;

  typedef struct packed {
    logic        global_inv;
    logic [15:0] interrupt_entry_index;
    logic [4:0]  index_mask;
  } iec_req_t;

  typedef struct packed {
    logic [61:0] addr;
    logic [31:0] data;
  } status_wr_t;

endpackage
`default_nettype wire

// [test/inv_exec_props.sv]
`include "inv_exec_map.svh"
`default_nettype none
module inv_exec_props
  import inv_exec_pkg::*;
#(
  parameter bit WRITE_BUFFER_FLUSH_REQUIRED = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb and descriptor stream
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic dsc_valid,
  input wire logic [127:0] dsc_data,
  input wire logic dsc_ready,
  // handler handshakes
  input wire logic wbf_ack,
  input wire logic tc_inv_req,
  input wire tc_req_t tc_inv,
  input wire logic ep_inv_req,
  input wire ep_req_t ep_inv,
  input wire logic ep_inv_ack,
  input wire logic ep_inv_cpl,
  input wire logic iec_inv_req,
  input wire iec_req_t iec_inv,
  input wire logic iec_inv_ack,
  input wire logic int_drain_req,
  input wire logic status_wr_req,
  input wire status_wr_t status_wr,
  input wire logic cpl_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // helper state
  // ----
  // the handlers present fields of the accepted descriptor, so keep our own copy
  logic [127:0] dsc_ff;
  logic [6:0] out_ff;
  wire logic [6:0] nxt_out = out_ff + {6'h00, ep_inv_ack} - {6'h00, ep_inv_cpl};
  wire logic [4:0] hint = dsc_ff[`EP_HINT_HI:`EP_HINT_LO];
  wire logic [6:0] lim = (hint == 5'h00) ? 7'h20 : {2'h0, hint};
  wire logic pg = (tc_inv.gran == `GRAN_PAGE);
  wire logic sel = dsc_ff[`IEC_GRAN];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsc_ff <= '0;
      out_ff <= '0;
    end else begin
      if (dsc_valid && dsc_ready) dsc_ff <= dsc_data;
      out_ff <= nxt_out;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // properties
  // ----
  property p_flush_tc;
    $rose(tc_inv_req) |-> !WRITE_BUFFER_FLUSH_REQUIRED || $past(wbf_ack);
  endproperty
  a_flush_tc: assert property (p_flush_tc) else $error("tc invalidation without flush");
  property p_flush_iec;
    $rose(iec_inv_req) |-> !WRITE_BUFFER_FLUSH_REQUIRED || $past(wbf_ack);
  endproperty
  a_flush_iec: assert property (p_flush_iec) else $error("iec invalidation without flush");
  property p_tc_fields;
    tc_inv_req |-> tc_inv.domain == ((tc_inv.gran == `GRAN_GLOBAL) ? 16'h0000 : dsc_ff[`TC_DID_HI:`TC_DID_LO])
      && {tc_inv.page, tc_inv.page_count_mask, tc_inv.directory_keep_hint} == (pg ?
      {dsc_ff[`D_PAGE_HI:`D_PAGE_LO], dsc_ff[`TC_AM_HI:`TC_AM_LO], dsc_ff[`TC_IH]} : 59'h0);
  endproperty
  a_tc_fields: assert property (p_tc_fields) else $error("tc request fields wrong");
  property p_ep_fields;
    ep_inv_req |-> ep_inv == {dsc_ff[`EP_RID_HI:`EP_RID_LO], dsc_ff[`D_PAGE_HI:`D_PAGE_LO], dsc_ff[`EP_SIZE]};
  endproperty
  a_ep_fields: assert property (p_ep_fields) else $error("endpoint request fields wrong");
  property p_ep_limit;
    ep_inv_req |-> out_ff < lim;
  endproperty
  a_ep_limit: assert property (p_ep_limit) else $error("endpoint request beyond limit");
  property p_idrain;
    iec_inv_req && iec_inv_ack |=> int_drain_req;
  endproperty
  a_idrain: assert property (p_idrain) else $error("no interrupt drain after iec");
  property p_iec_fields;
    iec_inv_req |-> iec_inv.global_inv == !sel && iec_inv.index_mask == (sel ? dsc_ff[`IEC_IM_HI:`IEC_IM_LO] : 5'h00);
  endproperty
  a_iec_fields: assert property (p_iec_fields) else $error("iec request fields wrong");
  property p_sw_fields;
    status_wr_req |-> status_wr == {dsc_ff[`WT_ADDR_HI:`WT_ADDR_LO], dsc_ff[`WT_DATA_HI:`WT_DATA_LO]};
  endproperty
  a_sw_fields: assert property (p_sw_fields) else $error("status write fields wrong");
  property p_order;
    status_wr_req |-> !cpl_event && !(psel && penable && pready);
  endproperty
  a_order: assert property (p_order) else $error("event or read passed a status write");
endmodule
bind invalidation_descriptor_executor inv_exec_props #(
  .WRITE_BUFFER_FLUSH_REQUIRED(WRITE_BUFFER_FLUSH_REQUIRED)
) inv_exec_props_inst (.*);
`default_nettype wire

// [test/inv_exec_partner.sv]
`default_nettype none
module inv_exec_partner (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pacing chosen by the bench
  input wire logic slow,
  input wire logic hold_cpl,
  // level requests from the block, answers back
  input wire logic [6:0] req,
  output logic [6:0] ack,
  output logic ep_cpl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // memory fabric and endpoint answers
  // ----
  logic [3:0] cnt_ff [7];
  logic [6:0] pend_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= '0;
      ep_cpl <= 1'b0;
      pend_ff <= '0;
      for (int i = 0; i < 7; i++) cnt_ff[i] <= '0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        // one pulse per request; never re-answers while the request drops
        ack[i] <= req[i] && !ack[i] && cnt_ff[i] >= (slow ? 4'h6 : 4'h0);
        cnt_ff[i] <= (req[i] && !ack[i]) ? cnt_ff[i] + 4'h1 : 4'h0;
      end
      // endpoint completes each accepted request once, unless held back to fill its queue
      ep_cpl <= pend_ff != 7'h00 && !ep_cpl && !hold_cpl;
      pend_ff <= pend_ff + {6'h00, ack[2]} - {6'h00, ep_cpl};
    end
  end
endmodule
`default_nettype wire

// [test/invalidation_descriptor_executor_tb.sv]
`include "inv_exec_map.svh"
`default_nettype none
module invalidation_descriptor_executor_tb
  import inv_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dsc_valid = 1'b0, slow = 1'b0, hold_cpl = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [127:0] dsc_data = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, dsc_ready, err, wbf_req, tc_inv_req, drain_rd_req, drain_wr_req, ep_inv_req;
  logic iec_inv_req, int_drain_req, status_wr_req, cpl_event, ep_cpl;
  logic [6:0] ack;
  tc_req_t tc_inv, tc_q;
  ep_req_t ep_inv;
  iec_req_t iec_inv, iec_q;
  status_wr_t status_wr, sw_q;
  int n_errors = 0, tests_run = 0, n_ev = 0, n_ep = 0, n_drn = 0, n_idr = 0, n_sw = 0, sw_drn = 0;
  always #5 pclk = ~pclk;
  invalidation_descriptor_executor invalidation_descriptor_executor_inst (
    .*,
    .wbf_ack(ack[6]),
    .status_wr_ack(ack[5]),
    .int_drain_ack(ack[4]),
    .iec_inv_ack(ack[3]),
    .ep_inv_ack(ack[2]),
    .drain_ack(ack[1]),
    .tc_inv_ack(ack[0]),
    .ep_inv_cpl(ep_cpl)
  );
  inv_exec_partner inv_exec_partner_inst (
    .pclk(pclk),
    .presetn(presetn),
    .slow(slow),
    .hold_cpl(hold_cpl),
    .req({wbf_req, status_wr_req, int_drain_req, iec_inv_req, ep_inv_req, drain_rd_req | drain_wr_req, tc_inv_req}),
    .ack(ack),
    .ep_cpl(ep_cpl)
  );
  always @(posedge pclk) begin
    if (cpl_event === 1'b1) n_ev <= n_ev + 1;
    if (ack[2] === 1'b1) n_ep <= n_ep + 1;
    if (ack[1] === 1'b1) n_drn <= n_drn + 1;
    if (ack[0] === 1'b1) tc_q <= tc_inv;
    if (ack[3] === 1'b1) iec_q <= iec_inv;
    if (ack[4] === 1'b1) n_idr <= n_idr + 1;
    if (ack[5] === 1'b1) begin
      n_sw <= n_sw + 1;
      sw_q <= status_wr;
      sw_drn <= n_drn;
    end
  end
  // ----
  // helpers
  // ----
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // look at settled levels mid-cycle; the answer is taken at the following rising edge
  task automatic hi(ref logic s);
    int k;
    k = 0;
    @(negedge pclk);
    while (s !== 1'b1 && k < 2000) begin
      @(negedge pclk);
      k++;
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    hi(pready);
    psel <= 1'b0;
    penable <= 1'b0;
    // let an idle edge pass so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic send(input logic [127:0] d);
    dsc_valid <= 1'b1;
    dsc_data <= d;
    hi(dsc_ready);
    dsc_valid <= 1'b0;
    dsc_data <= ~d;
    @(posedge pclk);
  endtask
  task automatic run(input logic [127:0] d);
    send(d);
    hi(dsc_ready);
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [127:0] wt(input logic fi, input logic sw);
    logic [127:0] d;
    d = '0;
    d[`D_TYPE_HI:`D_TYPE_LO] = `DT_WAIT;
    d[`WT_IF] = fi;
    d[`WT_SW] = sw;
    d[`WT_FN] = 1'b1;
    d[`WT_DATA_HI:`WT_DATA_LO] = 32'hc0de_0001;
    d[`WT_ADDR_HI:`WT_ADDR_LO] = 62'h400;
    return d;
  endfunction
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    apb(1'b0, `REG_EVT_CTRL, 32'h0000_0000);
    check(rd[`MASK_BIT], `MASK_RESET, "mask reset");
    apb(1'b0, `REG_CAPABILITY, 32'h0000_0000);
    check(rd[0], 1'b1, "flush capability");
    apb(1'b1, 12'h010, 32'hffff_ffff);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
    $display("registers done");
  endtask
  task automatic t_tc();
    logic [127:0] d;
    for (int g = 1; g < 4; g++) begin
      d = '0;
      d[`D_TYPE_HI:`D_TYPE_LO] = `DT_TC;
      d[`TC_GRAN_HI:`TC_GRAN_LO] = g[1:0];
      d[`TC_DR] = 1'b1;
      d[`TC_DW] = 1'b1;
      d[`TC_DID_HI:`TC_DID_LO] = 16'h00a5;
      d[`D_PAGE_HI:`D_PAGE_LO] = 52'h12345;
      d[`TC_AM_HI:`TC_AM_LO] = 6'h03;
      d[`TC_IH] = 1'b1;
      run(d);
      check(tc_q.domain, (g == 1) ? 16'h0000 : 16'h00a5, "domain");
      check({tc_q.page, tc_q.page_count_mask, tc_q.directory_keep_hint},
        (g == 3) ? {52'h12345, 6'h03, 1'b1} : 59'h0, "page fields");
    end
    run(wt(1'b0, 1'b1));
    check(sw_drn, 1, "drain before status write");
    check(sw_q, {62'h400, 32'hc0de_0001}, "status write");
    $display("tc done");
  endtask
  task automatic t_ep();
    logic [127:0] d;
    int e;
    e = n_ep;
    d = '0;
    d[`D_TYPE_HI:`D_TYPE_LO] = `DT_EP;
    d[`EP_HINT_HI:`EP_HINT_LO] = 5'h02;
    d[`EP_RID_HI:`EP_RID_LO] = 16'h0118;
    d[`EP_SIZE] = 1'b1;
    d[`D_PAGE_HI:`D_PAGE_LO] = 52'h00abd;
    hold_cpl <= 1'b1;
    repeat (3) send(d);
    repeat (20) @(posedge pclk);
    check({n_ep - e, dsc_ready}, {32'h2, 1'b0}, "throttled");
    hold_cpl <= 1'b0;
    hi(dsc_ready);
    check(n_ep - e, 3, "released");
    $display("endpoint done");
  endtask
  task automatic t_iec();
    logic [127:0] d;
    int i;
    for (int m = 0; m < 2; m++) begin
      i = n_idr;
      d = '0;
      d[`D_TYPE_HI:`D_TYPE_LO] = `DT_IEC;
      d[`IEC_GRAN] = m[0];
      d[`IEC_IDX_HI:`IEC_IDX_LO] = 16'h0034;
      d[`IEC_IM_HI:`IEC_IM_LO] = 5'h02;
      run(d);
      check({iec_q.global_inv, iec_q.index_mask}, {!m[0], m[0] ? 5'h02 : 5'h00}, "iec scope");
      check(n_idr - i, 1, "interrupt drain");
    end
    check(iec_q.interrupt_entry_index, 16'h0034, "iec index");
    $display("iec done");
  endtask
  task automatic t_evt();
    int e, s;
    e = n_ev;
    s = n_sw;
    apb(1'b1, `REG_CPL_STATUS, 32'h0000_0001);
    run(wt(1'b1, 1'b0));
    apb(1'b0, `REG_CPL_STATUS, 32'h0000_0000);
    check(rd[`WC_BIT], 1'b1, "wait complete set");
    apb(1'b0, `REG_EVT_CTRL, 32'h0000_0000);
    check({n_ev - e, rd[`PEND_BIT]}, {32'h0, 1'b1}, "held while masked");
    apb(1'b1, `REG_EVT_CTRL, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    check(n_ev - e, 1, "unmask fires");
    run(wt(1'b1, 1'b0));
    check({n_ev - e, n_sw - s}, {32'h1, 32'h0}, "already set, no status write");
    apb(1'b1, `REG_EVT_CTRL, 32'h8000_0000);
    apb(1'b1, `REG_CPL_STATUS, 32'h0000_0001);
    run(wt(1'b1, 1'b0));
    apb(1'b1, `REG_CPL_STATUS, 32'h0000_0001);
    apb(1'b1, `REG_EVT_CTRL, 32'h0000_0000);
    apb(1'b0, `REG_EVT_CTRL, 32'h0000_0000);
    check({n_ev - e, rd[`PEND_BIT]}, {32'h1, 1'b0}, "serviced drops pending");
    apb(1'b1, `REG_CPL_STATUS, 32'h0000_0001);
    run(wt(1'b1, 1'b0));
    check(n_ev - e, 2, "unmasked fires");
    $display("events done");
  endtask
  task automatic t_order();
    int s;
    s = n_sw;
    slow <= 1'b1;
    send(wt(1'b0, 1'b1));
    hi(status_wr_req);
    apb(1'b0, `REG_CPL_STATUS, 32'h0000_0000);
    check(n_sw - s, 1, "read behind status write");
    slow <= 1'b0;
    run({124'h0, 4'h7});
    apb(1'b0, `REG_EXEC_STATUS, 32'h0000_0000);
    check(rd[`BADTYPE_BIT], 1'b1, "unknown type flagged");
    $display("ordering done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tc();
    t_ep();
    t_iec();
    t_evt();
    t_order();
    print_verdict();
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
